/* File: design/axs_seq_step_config.sv */
// Purpose: Step 2 and step 3 configuration of the converter-B sequencer
// Assumes: Register port and step requests are on the clock's own domain
// Notes:   Reads answer one cycle after the strobe; ce low freezes all state
`include "axs_defines.svh"

// Overview of operation
// - Bit 15 enables step 2 when set, disables it when clear.
// - Bits 14:13 pick gain: 00 gives 1, 01 gives 2, 10/11 give 4.
// - Bits 12:5 are reserved, read-only, always read zero.
// - Bit 4 picks negative input: analog ground B or input seven B.
// - Bits 3:0 pick positive input: codes 0-4, 6, 7 select external inputs.
// - Code 1000 routes temperature sensor, 1001 internal short; negative automatic.
// - Codes 1011, 1110, 1111 route supply quarter, power pins /103; automatic.
// - With automatic negative routing the negative select bit is ignored.
// - Step 2 register at D2h resets to 0002h.
// - Step 3 register at D3h resets to 0003h.
// - Positive code 0101 selects external input five of side B.
// - Positive code 1100 routes I/O supply quarter, negative automatic.
module axs_seq_step_config (
   input  wire logic              clock,
   input  wire logic              nrst,
   input  wire logic              ce,
   input  wire logic [7:0]        reg_addr,
   input  wire logic              reg_wr,
   input  wire logic [15:0]       reg_wdata,
   input  wire logic              reg_rd,
   output logic [15:0]            reg_rdata,
   input  wire logic              step_req,
   input  wire logic [3:0]        step_index,
   output logic                   conv_start,
   output logic                   step_skip,
   output logic [1:0]             conv_gain_shift,
   output logic [3:0]             conv_pos_code,
   output logic                   conv_neg_auto,
   output logic                   conv_neg_ext7
);
   localparam int NSTEPS = 2;
   localparam logic [7:0] STEP_ADDR [NSTEPS] =
      '{`AXS_ADDR_STEP2, `AXS_ADDR_STEP3};
   localparam logic [15:0] STEP_RESET [NSTEPS] =
      '{`AXS_RESET_STEP2, `AXS_RESET_STEP3};

   wire logic [NSTEPS-1:0] hit;
   wire logic [NSTEPS-1:0] wr_hit;
   wire logic [15:0]       rd_word [NSTEPS];
   wire logic [NSTEPS-1:0] en_v;
   wire logic [1:0]        gain_v  [NSTEPS];
   wire logic [NSTEPS-1:0] neg_v;
   wire logic [3:0]        pos_v   [NSTEPS];

   genvar i;
   generate
      for (i = 0; i < NSTEPS; i++) begin : g_step
         axs_step_if cfg_if ();
         assign hit[i]    = (reg_addr == STEP_ADDR[i]);
         assign wr_hit[i] = ce & reg_wr & hit[i];
         axs_step_reg #(
            .RESET_VALUE (STEP_RESET[i])
         ) u_reg (
            .clock (clock),
            .nrst  (nrst),
            .wr_en (wr_hit[i]),
            .wdata (reg_wdata),
            .rdata (rd_word[i]),
            .cfg   (cfg_if)
         );
         assign en_v[i]   = cfg_if.enable;
         assign gain_v[i] = cfg_if.gain;
         assign neg_v[i]  = cfg_if.neg;
         assign pos_v[i]  = cfg_if.pos;
      end
   endgenerate

   // Register read selection; unmapped addresses read as zero
   wire logic [15:0] rd_sel;
   assign rd_sel = hit[0] ? rd_word[0] :
                   hit[1] ? rd_word[1] : `AXS_READ_IDLE;

   // Step selection for the sequencer; other indices belong elsewhere
   wire logic is_step2;
   wire logic is_step3;
   wire logic idx_ok;
   wire logic sel;
   assign is_step2 = (step_index == `AXS_INDEX_STEP2);
   assign is_step3 = (step_index == `AXS_INDEX_STEP3);
   assign idx_ok   = is_step2 | is_step3;
   assign sel      = is_step3;

   axs_step_if sel_if ();
   assign sel_if.enable = en_v[sel];
   assign sel_if.gain   = gain_v[sel];
   assign sel_if.neg    = neg_v[sel];
   assign sel_if.pos    = pos_v[sel];

   axs_pkg::axs_src_e dec_kind;
   wire logic [3:0]   dec_pos;
   wire logic         dec_neg_auto;
   wire logic         dec_neg_ext7;
   wire logic [1:0]   dec_shift;

   axs_mux_decode u_dec (
      .cfg        (sel_if),
      .kind       (dec_kind),
      .pos_code   (dec_pos),
      .neg_auto   (dec_neg_auto),
      .neg_ext7   (dec_neg_ext7),
      .gain_shift (dec_shift)
   );

   wire logic take;
   wire logic go;
   wire logic skip;
   assign take = ce & step_req & idx_ok;
   assign go   = take & sel_if.enable;
   assign skip = take & ~sel_if.enable;

   logic [15:0] rdata_q;
   logic        start_q;
   logic        skip_q;
   logic [1:0]  shift_q;
   logic [3:0]  pos_q;
   logic        auto_q;
   logic        ext7_q;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= `AXS_READ_IDLE;
      end else if (ce && reg_rd) begin
         rdata_q <= rd_sel;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         start_q <= 1'h0;
         skip_q  <= 1'h0;
      end else if (ce) begin
         start_q <= go;
         skip_q  <= skip;
      end
   end

   // Routing holds from one applied step until the next one
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         shift_q <= `AXS_SHIFT_X1;
         pos_q   <= STEP_RESET[0][`AXS_POS_HI:`AXS_POS_LO];
         auto_q  <= 1'h0;
         ext7_q  <= 1'h0;
      end else if (go) begin
         shift_q <= dec_shift;
         pos_q   <= dec_pos;
         auto_q  <= dec_neg_auto;
         ext7_q  <= dec_neg_ext7;
      end
   end

   assign reg_rdata       = rdata_q;
   assign conv_start      = start_q;
   assign step_skip       = skip_q;
   assign conv_gain_shift = shift_q;
   assign conv_pos_code   = pos_q;
   assign conv_neg_auto   = auto_q;
   assign conv_neg_ext7   = ext7_q;

   // Helper: a register not yet written must still show its reset value
   logic [NSTEPS-1:0] touched_q;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         touched_q <= '0;
      end else begin
         touched_q <= touched_q | wr_hit;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   property p_enable_write;
      (wr_hit[0] && reg_wdata[`AXS_EN_BIT]) |=> en_v[0];
   endproperty
   a_enable_write: assert property (p_enable_write)
      else $error("step 2 enable not stored");

   property p_gain;
      go |=> conv_gain_shift ==
         ($past(sel_if.gain) == 2'h0 ? 2'h0 :
          $past(sel_if.gain) == 2'h1 ? 2'h1 : 2'h2);
   endproperty
   a_gain: assert property (p_gain)
      else $error("applied gain does not match gain code");

   property p_reserved;
      (ce && reg_rd && (hit != '0)) |=> reg_rdata[12:5] == 8'h00;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved field read nonzero");

   property p_neg_manual;
      (go && !sel_if.pos[3]) |=>
         !conv_neg_auto && conv_neg_ext7 == $past(sel_if.neg);
   endproperty
   a_neg_manual: assert property (p_neg_manual)
      else $error("manual negative input not applied");

   property p_pos;
      go |=> conv_pos_code == $past(sel_if.pos);
   endproperty
   a_pos: assert property (p_pos)
      else $error("positive code not applied");

   property p_temp_short;
      (sel_if.pos == 4'h8 |-> dec_kind == axs_pkg::src_temp && dec_neg_auto)
      and
      (sel_if.pos == 4'h9 |-> dec_kind == axs_pkg::src_short && dec_neg_auto);
   endproperty
   a_temp_short: assert property (p_temp_short)
      else $error("temperature or short code misrouted");

   property p_supply;
      (sel_if.pos == 4'hE) |-> dec_kind == axs_pkg::src_analog_power_pin_div
         && dec_neg_auto;
   endproperty
   a_supply: assert property (p_supply)
      else $error("power pin code misrouted");

   property p_neg_ignored;
      (go && sel_if.pos[3]) |=> conv_neg_auto && !conv_neg_ext7;
   endproperty
   a_neg_ignored: assert property (p_neg_ignored)
      else $error("negative bit used with automatic routing");

   property p_reset2;
      (ce && reg_rd && hit[0] && !touched_q[0]) |=>
         reg_rdata == 16'h0002;
   endproperty
   a_reset2: assert property (p_reset2)
      else $error("step 2 register lost its reset value");

   property p_reset3;
      (ce && reg_rd && hit[1] && !touched_q[1]) |=>
         reg_rdata == 16'h0003;
   endproperty
   a_reset3: assert property (p_reset3)
      else $error("step 3 register lost its reset value");

   property p_input5;
      (sel_if.pos == 4'h5) |-> dec_kind == axs_pkg::src_ext
         && !dec_neg_auto;
   endproperty
   a_input5: assert property (p_input5)
      else $error("input five code misrouted");

   property p_io_quarter;
      (sel_if.pos == 4'hC) |-> dec_kind == axs_pkg::src_io_quarter
         && dec_neg_auto;
   endproperty
   a_io_quarter: assert property (p_io_quarter)
      else $error("I/O supply code misrouted");

   // Pulse may stretch only for a back-to-back skip or a frozen cycle
   property p_skip;
      skip |=> step_skip && !conv_start ##1
         (!step_skip || $past(skip) || !$past(ce));
   endproperty
   a_skip: assert property (p_skip)
      else $error("disabled step was not skipped");

   property p_skip_hold;
      skip |=> $stable(conv_pos_code) && $stable(conv_gain_shift);
   endproperty
   a_skip_hold: assert property (p_skip_hold)
      else $error("skipped step changed the routing");

   property p_start;
      go |=> conv_start && !step_skip;
   endproperty
   a_start: assert property (p_start)
      else $error("enabled step was not started");

   property p_ext_inputs;
      !sel_if.pos[3] |-> dec_kind == axs_pkg::src_ext && !dec_neg_auto;
   endproperty
   a_ext_inputs: assert property (p_ext_inputs)
      else $error("external input code misrouted");

   property p_quarter;
      (sel_if.pos == 4'hB) |-> dec_kind == axs_pkg::src_analog_quarter
         && dec_neg_auto;
   endproperty
   a_quarter: assert property (p_quarter)
      else $error("analog supply quarter code misrouted");

   property p_digital_power_pin;
      (sel_if.pos == 4'hF) |-> dec_kind == axs_pkg::src_digital_power_pin_div
         && dec_neg_auto;
   endproperty
   a_digital_power_pin: assert property (p_digital_power_pin)
      else $error("digital power pin code misrouted");

   property p_step3_write;
      wr_hit[1] |=> rd_word[1] == ($past(reg_wdata) & 16'hE01F);
   endproperty
   a_step3_write: assert property (p_step3_write)
      else $error("step 3 register write not stored");
endmodule

/* File: design/axs_defines.svh */
// Purpose: Named constants for the converter-B step configuration block
// Assumes: Included by bare name from every design file that needs it
// Notes:   Definitions only
`ifndef AXS_DEFINES_SVH
`define AXS_DEFINES_SVH

`define AXS_ADDR_W       8
`define AXS_DATA_W       16
`define AXS_ADDR_STEP2   8'hD2
`define AXS_ADDR_STEP3   8'hD3
`define AXS_RESET_STEP2  16'h0002
`define AXS_RESET_STEP3  16'h0003
`define AXS_INDEX_STEP2  4'h2
`define AXS_INDEX_STEP3  4'h3
`define AXS_READ_IDLE    16'h0000

`define AXS_EN_BIT       15
`define AXS_GAIN_HI      14
`define AXS_GAIN_LO      13
`define AXS_RSVD_HI      12
`define AXS_RSVD_LO      5
`define AXS_RSVD_ZERO    8'h00
`define AXS_NEG_BIT      4
`define AXS_POS_HI       3
`define AXS_POS_LO       0
`define AXS_AUTO_BIT     3

`define AXS_GAIN_CODE_X1 2'h0
`define AXS_GAIN_CODE_X2 2'h1
`define AXS_SHIFT_X1     2'h0
`define AXS_SHIFT_X2     2'h1
`define AXS_SHIFT_X4     2'h2

`define AXS_POS_EXT5     4'h5
`define AXS_POS_TEMP     4'h8
`define AXS_POS_SHORT    4'h9
`define AXS_POS_TEST     4'hA
`define AXS_POS_ANALOG_SUPPLY_Q   4'hB
`define AXS_POS_IO_SUPPLY_Q  4'hC
`define AXS_POS_DIGITAL_CORE_SUPPLY_H   4'hD
`define AXS_POS_ANALOG_POWER_PIN     4'hE
`define AXS_POS_DIGITAL_POWER_PIN     4'hF

`endif

/* File: design/axs_pkg.sv */
// Purpose: Types and decode functions shared by the step configuration block
// Assumes: axs_defines.svh holds every code and bit position
// Notes:   Positive codes with the top bit set pick the negative input
`include "axs_defines.svh"

package axs_pkg;

   typedef enum logic [3:0] {
      src_ext,
      src_temp,
      src_short,
      src_test,
      src_analog_quarter,
      src_io_quarter,
      src_core_half,
      src_analog_power_pin_div,
      src_digital_power_pin_div
   } axs_src_e;

   function automatic logic axs_auto_neg(input logic [3:0] code);
      axs_auto_neg = code[`AXS_AUTO_BIT];
   endfunction

   function automatic axs_src_e axs_src_of(input logic [3:0] code);
      case (code)
         `AXS_POS_TEMP:    axs_src_of = src_temp;
         `AXS_POS_SHORT:   axs_src_of = src_short;
         `AXS_POS_TEST:    axs_src_of = src_test;
         `AXS_POS_ANALOG_SUPPLY_Q:  axs_src_of = src_analog_quarter;
         `AXS_POS_IO_SUPPLY_Q: axs_src_of = src_io_quarter;
         `AXS_POS_DIGITAL_CORE_SUPPLY_H:  axs_src_of = src_core_half;
         `AXS_POS_ANALOG_POWER_PIN:    axs_src_of = src_analog_power_pin_div;
         `AXS_POS_DIGITAL_POWER_PIN:    axs_src_of = src_digital_power_pin_div;
         default:          axs_src_of = src_ext;
      endcase
   endfunction

endpackage

/* File: design/axs_step_if.sv */
// Purpose: Carries one sequence step's configuration fields
// Assumes: One provider, any number of consumers
// Notes:   Fields are live register values, not pulses
interface axs_step_if;
   logic       enable;
   logic [1:0] gain;
   logic       neg;
   logic [3:0] pos;
   modport prov (output enable, gain, neg, pos);
   modport cons (input enable, gain, neg, pos);
endinterface

/* File: design/axs_step_reg.sv */
// Purpose: One sequence step configuration register
// Assumes: Write strobe already qualified by address and clock enable
// Notes:   Reserved field is not stored, so it always reads zero
`include "axs_defines.svh"

module axs_step_reg #(
   parameter logic [15:0] RESET_VALUE = `AXS_RESET_STEP2
) (
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic        wr_en,
   input  wire logic [15:0] wdata,
   output logic [15:0]      rdata,
   axs_step_if.prov         cfg
);
   logic       en_q;
   logic [1:0] gain_q;
   logic       neg_q;
   logic [3:0] pos_q;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         en_q   <= RESET_VALUE[`AXS_EN_BIT];
         gain_q <= RESET_VALUE[`AXS_GAIN_HI:`AXS_GAIN_LO];
         neg_q  <= RESET_VALUE[`AXS_NEG_BIT];
         pos_q  <= RESET_VALUE[`AXS_POS_HI:`AXS_POS_LO];
      end else if (wr_en) begin
         en_q   <= wdata[`AXS_EN_BIT];
         gain_q <= wdata[`AXS_GAIN_HI:`AXS_GAIN_LO];
         neg_q  <= wdata[`AXS_NEG_BIT];
         pos_q  <= wdata[`AXS_POS_HI:`AXS_POS_LO];
      end
   end

   assign rdata      = {en_q, gain_q, `AXS_RSVD_ZERO, neg_q, pos_q};
   assign cfg.enable = en_q;
   assign cfg.gain   = gain_q;
   assign cfg.neg    = neg_q;
   assign cfg.pos    = pos_q;
endmodule

/* File: design/axs_mux_decode.sv */
// Purpose: Turns a step's fields into converter gain and input routing
// Assumes: Purely combinational; caller registers the results except kind
// Notes:   Negative select bit is masked whenever routing is automatic
`include "axs_defines.svh"

module axs_mux_decode (
   axs_step_if.cons          cfg,
   output axs_pkg::axs_src_e kind,
   output logic [3:0]        pos_code,
   output logic              neg_auto,
   output logic              neg_ext7,
   output logic [1:0]        gain_shift
);
   wire logic gain_x1;
   wire logic gain_x2;

   assign gain_x1    = (cfg.gain == `AXS_GAIN_CODE_X1);
   assign gain_x2    = (cfg.gain == `AXS_GAIN_CODE_X2);
   // Both upper gain codes land on the top gain
   assign gain_shift = gain_x1 ? `AXS_SHIFT_X1 :
                       gain_x2 ? `AXS_SHIFT_X2 : `AXS_SHIFT_X4;
   assign kind       = axs_pkg::axs_src_of(cfg.pos);
   assign pos_code   = cfg.pos;
   assign neg_auto   = axs_pkg::axs_auto_neg(cfg.pos);
   assign neg_ext7   = cfg.neg & ~neg_auto;
endmodule

/* File: tb/axs_seq_step_config_tb_top.sv */
// Purpose: Self-checking bench for the converter-B step configuration block
// Assumes: Inputs change on the falling edge; answers land one edge later
// Notes:   Model keeps both step registers and the last applied routing
module axs_seq_step_config_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clock;
   logic        nrst;
   logic        ce;
   logic [7:0]  reg_addr;
   logic        reg_wr;
   logic [15:0] reg_wdata;
   logic        reg_rd;
   logic [15:0] reg_rdata;
   logic        step_req;
   logic [3:0]  step_index;
   logic        conv_start;
   logic        step_skip;
   logic [1:0]  conv_gain_shift;
   logic [3:0]  conv_pos_code;
   logic        conv_neg_auto;
   logic        conv_neg_ext7;

   int          err_total;
   int          samples_checked;
   int          seed;
   logic [15:0] mreg [2];
   logic [7:0]  mroute;
   logic [15:0] wd;

   axs_seq_step_config u_dut (
      .clock           (clock),
      .nrst            (nrst),
      .ce              (ce),
      .reg_addr        (reg_addr),
      .reg_wr          (reg_wr),
      .reg_wdata       (reg_wdata),
      .reg_rd          (reg_rd),
      .reg_rdata       (reg_rdata),
      .step_req        (step_req),
      .step_index      (step_index),
      .conv_start      (conv_start),
      .step_skip       (step_skip),
      .conv_gain_shift (conv_gain_shift),
      .conv_pos_code   (conv_pos_code),
      .conv_neg_auto   (conv_neg_auto),
      .conv_neg_ext7   (conv_neg_ext7)
   );

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                      input string what);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: %s got %h expected %h",
                  $time, what, got, exp);
      end
   endtask

   // Gain shift, positive code, automatic flag, input-seven flag
   function automatic logic [7:0] route_of(input logic [15:0] d);
      logic [1:0] sh;
      logic       au;
      sh = (d[14:13] == 2'h0) ? 2'h0 : (d[14:13] == 2'h1) ? 2'h1 : 2'h2;
      au = d[3];
      route_of = {sh, d[3:0], au, au ? 1'b0 : d[4]};
   endfunction

   function automatic logic [15:0] model_rd(input logic [7:0] a);
      model_rd = (a == 8'hD2) ? mreg[0] :
                 (a == 8'hD3) ? mreg[1] : 16'h0000;
   endfunction

   task automatic model_reset();
      mreg[0] = 16'h0002;
      mreg[1] = 16'h0003;
      mroute = route_of(16'h0002);
   endtask

   function automatic logic [15:0] routing();
      routing = {8'h00, conv_gain_shift, conv_pos_code, conv_neg_auto,
                 conv_neg_ext7};
   endfunction

   // Reserved bits are never stored, so the model masks them off
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clock);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      if (ce && a == 8'hD2) mreg[0] = d & 16'hE01F;
      if (ce && a == 8'hD3) mreg[1] = d & 16'hE01F;
      @(negedge clock);
      reg_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(negedge clock);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clock);
      reg_rd = 1'b0;
      chk(reg_rdata, model_rd(a), "read data");
   endtask

   task automatic step(input logic [3:0] idx);
      logic mine;
      logic en;
      mine = (idx == 4'h2) || (idx == 4'h3);
      en = mine && mreg[idx[0]][15];
      if (en) mroute = route_of(mreg[idx[0]]);
      @(negedge clock);
      step_req = 1'b1;
      step_index = idx;
      @(negedge clock);
      step_req = 1'b0;
      chk({14'h0, conv_start, step_skip}, {14'h0, en, mine && !en},
          "step answer");
      chk(routing(), {8'h00, mroute}, "routing");
      @(negedge clock);
      chk({14'h0, conv_start, step_skip}, 16'h0000, "pulse end");
   endtask

   initial begin
      seed = 97;
      err_total = 0;
      samples_checked = 0;
      nrst = 1'b0;
      ce = 1'b1;
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 16'h0000;
      reg_rd = 1'b0;
      step_req = 1'b0;
      step_index = 4'h0;
      model_reset();
      repeat (10) @(negedge clock);
      nrst = 1'b1;
      chk(reg_rdata, 16'h0000, "reset read data");
      chk(routing(), {8'h00, mroute}, "reset routing");
      rd(8'hD2);
      rd(8'hD3);
      wr(8'hD2, 16'hFFFF);
      rd(8'hD2);
      // Unmapped place: write dropped, read gives zero
      wr(8'hD4, 16'h1234);
      rd(8'hD4);
      // Frozen clock enable must drop the write
      ce = 1'b0;
      wr(8'hD2, 16'h0000);
      ce = 1'b1;
      rd(8'hD2);
      // Every positive code, all gain codes, random negative and reserved
      for (int k = 0; k < 16; k++) begin
         wd = 16'($random(seed));
         wd[15] = 1'b1;
         wd[14:13] = 2'(k);
         wd[3:0] = 4'(k);
         wr(8'hD2, wd);
         rd(8'hD2);
         step(4'h2);
      end
      // Disabled step is skipped and routing holds
      wr(8'hD2, 16'h0015);
      step(4'h2);
      step(4'h3);
      wr(8'hD3, 16'hA01B);
      rd(8'hD3);
      step(4'h3);
      step(4'h7);
      // Second reset in mid-run
      @(negedge clock);
      nrst = 1'b0;
      model_reset();
      repeat (3) @(negedge clock);
      nrst = 1'b1;
      chk(reg_rdata, 16'h0000, "second reset read data");
      chk(routing(), {8'h00, mroute}, "second reset routing");
      rd(8'hD2);
      rd(8'hD3);
      step(4'h2);
      give_verdict();
   end

   initial begin
      #200000;
      err_total++;
      $display("mismatch at %0t: run did not finish", $time);
      give_verdict();
   end
endmodule
